//--- bench/ebr_host_model.sv
// Host software model driving the command/status and data ports
`timescale 1ns/1ps

module ebr_host_model (
    input wire logic clock_i,
    output logic host_wr_o,
    output logic host_rd_o,
    output logic host_sel_cmd_o,
    output logic [7:0] host_wdata_o,
    input wire logic [7:0] host_rdata_i
);
    initial begin
        host_wr_o = 1'b0;
        host_rd_o = 1'b0;
        host_sel_cmd_o = 1'b1;
        host_wdata_o = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobes held 4 cycles high and 4 low, clear of the 3-stage filter
    task automatic put_byte(input logic sel, input logic [7:0] data);
        @(negedge clock_i);
        host_sel_cmd_o = sel;
        host_wdata_o = data;
        host_wr_o = 1'b1;
        repeat (4) @(negedge clock_i);
        host_wr_o = 1'b0;
        // Released bus shows the inverse, never a stale byte
        host_wdata_o = ~data;
        repeat (4) @(negedge clock_i);
    endtask

    // Data port read also clears the output buffer flag
    task automatic get_byte(input logic sel, output logic [7:0] data);
        @(negedge clock_i);
        host_sel_cmd_o = sel;
        repeat (2) @(negedge clock_i);
        data = host_rdata_i;
        if (!sel) begin
            host_rd_o = 1'b1;
            repeat (4) @(negedge clock_i);
            host_rd_o = 1'b0;
            repeat (4) @(negedge clock_i);
        end
    endtask
endmodule

//--- bench/test_ebr_host_cmd.sv
// Self-checking bench for the host command interpreter and battery RAM
`timescale 1ns/1ps

module test_ebr_host_cmd;
    import ebr_pkg::*;

    logic clock_i, resetn_i, host_wr_i, host_rd_i, host_sel_cmd_i, sci_o, query_evt_i;
    logic smb_valid_i, smb_done_o, smb_err_o, upd_valid_i;
    logic [7:0] host_wdata_i, host_rdata_o, query_code_i, smb_cmd_i, d;
    logic [EBR_IDX_W-1:0] smb_idx_i, upd_idx_i;
    logic [15:0] smb_wdata_i, smb_rdata_o, upd_data_i;
    int err_count = 0;
    int comparisons = 0;
    int sci_seen = 0;
    int exp_sci = 0;

    ebr_host_cmd ebr_host_cmd_i (.clock_i(clock_i), .resetn_i(resetn_i), .host_wr_i(host_wr_i),
        .host_rd_i(host_rd_i), .host_sel_cmd_i(host_sel_cmd_i), .host_wdata_i(host_wdata_i),
        .host_rdata_o(host_rdata_o), .sci_o(sci_o), .query_evt_i(query_evt_i), .query_code_i(query_code_i),
        .smb_valid_i(smb_valid_i), .smb_cmd_i(smb_cmd_i), .smb_idx_i(smb_idx_i), .smb_wdata_i(smb_wdata_i),
        .smb_rdata_o(smb_rdata_o), .smb_done_o(smb_done_o), .smb_err_o(smb_err_o),
        .upd_valid_i(upd_valid_i), .upd_idx_i(upd_idx_i), .upd_data_i(upd_data_i));

    ebr_host_model ebr_host_model_i (.clock_i(clock_i), .host_wr_o(host_wr_i), .host_rd_o(host_rd_i),
        .host_sel_cmd_o(host_sel_cmd_i), .host_wdata_o(host_wdata_i), .host_rdata_i(host_rdata_o));

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // Counts high cycles, so a stretched pulse shows up as extra
    always @(posedge clock_i) begin
        if (sci_o === 1'b1) sci_seen <= sci_seen + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic sci_chk(input int n);
        exp_sci += n;
        chk8("interrupt count", exp_sci[7:0], sci_seen[7:0]);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic ec_read(input logic [7:0] addr, input logic [7:0] exp);
        ebr_host_model_i.put_byte(1'b1, EBR_CMD_READ);
        ebr_host_model_i.put_byte(1'b0, addr);
        sci_chk(2);
        ebr_host_model_i.get_byte(1'b1, d);
        chk8("status before read", 8'h01, d);
        ebr_host_model_i.get_byte(1'b0, d);
        chk8("read byte", exp, d);
        ebr_host_model_i.get_byte(1'b1, d);
        chk8("status after read", 8'h00, d);
    endtask

    task automatic ec_write(input logic [7:0] addr, input logic [7:0] data);
        ebr_host_model_i.put_byte(1'b1, EBR_CMD_WRITE);
        sci_chk(1);
        ebr_host_model_i.put_byte(1'b0, addr);
        sci_chk(1);
        ebr_host_model_i.put_byte(1'b0, data);
        sci_chk(1);
    endtask

    task automatic smb(input logic [7:0] cmd, input logic [EBR_IDX_W-1:0] idx, input logic [15:0] wd,
                       input logic [15:0] exp, input logic err);
        @(negedge clock_i);
        smb_valid_i = 1'b1;
        smb_cmd_i = cmd;
        smb_idx_i = idx;
        smb_wdata_i = wd;
        // Done and error stand only for the cycle after the request edge
        @(negedge clock_i);
        chk8("smbus done and error", {6'h00, ~err, err}, {6'h00, smb_done_o, smb_err_o});
        if (!err && cmd == EBR_SMB_READ) chk16("smbus word", exp, smb_rdata_o);
        smb_valid_i = 1'b0;
        smb_wdata_i = ~wd;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        $display("BAD watchdog expected finish seen hang");
        results();
    end

    initial begin
        resetn_i = 1'b0;
        query_evt_i = 1'b0;
        query_code_i = 8'h00;
        smb_valid_i = 1'b0;
        smb_cmd_i = 8'h00;
        smb_idx_i = '0;
        smb_wdata_i = 16'h0000;
        upd_valid_i = 1'b0;
        upd_idx_i = '0;
        upd_data_i = 16'h0000;
        repeat (5) @(negedge clock_i);
        resetn_i = 1'b1;
        ebr_host_model_i.get_byte(1'b1, d);
        chk8("status after reset", 8'h00, d);
        $display("test reset finished");
        ec_read(EBR_OFF_POWER_UNIT, 8'h00);
        ec_read(8'h01, 8'h00);
        ec_read(8'h03, 8'hFF);
        ec_read(EBR_RAM_BYTES, 8'h00);
        $display("test host read finished");
        ec_write(EBR_OFF_DESIGN_CAP, 8'h34);
        ec_write(8'h03, 8'h12);
        smb(EBR_SMB_READ, 3'h1, 16'h0000, 16'h1234, 1'b0);
        ebr_host_model_i.put_byte(1'b1, 8'h55);
        sci_chk(0);
        $display("test host write finished");
        ebr_host_model_i.put_byte(1'b1, EBR_CMD_BURST_ON);
        sci_chk(1);
        ebr_host_model_i.get_byte(1'b1, d);
        chk8("burst status", 8'h19, d);
        ebr_host_model_i.get_byte(1'b0, d);
        chk8("burst ack", EBR_BURST_ACK, d);
        ebr_host_model_i.put_byte(1'b1, EBR_CMD_BURST_OFF);
        sci_chk(1);
        ebr_host_model_i.get_byte(1'b1, d);
        chk8("burst off status", 8'h08, d);
        @(negedge clock_i);
        query_evt_i = 1'b1;
        query_code_i = 8'h5A;
        @(negedge clock_i);
        query_evt_i = 1'b0;
        // Pulse is registered, then counted one edge later
        @(negedge clock_i);
        sci_chk(1);
        ebr_host_model_i.get_byte(1'b1, d);
        chk8("event status", 8'h28, d);
        ebr_host_model_i.put_byte(1'b1, EBR_CMD_QUERY);
        sci_chk(1);
        ebr_host_model_i.get_byte(1'b0, d);
        chk8("query value", 8'h5A, d);
        ebr_host_model_i.get_byte(1'b1, d);
        chk8("query status", 8'h08, d);
        $display("test burst and query finished");
        smb(EBR_SMB_WRITE, 3'h4, 16'hBEEF, 16'h0000, 1'b0);
        smb(EBR_SMB_READ, 3'h4, 16'h0000, 16'hBEEF, 1'b0);
        ec_read(8'h09, 8'hBE);
        smb(EBR_SMB_WRITE, 3'h0, 16'h1357, 16'h0000, 1'b0);
        smb(EBR_SMB_READ, 3'h0, 16'h0000, 16'h0000, 1'b0);
        smb(8'h55, 3'h2, 16'h0000, 16'h0000, 1'b1);
        ec_write(EBR_OFF_TECHNOLOGY, 8'h78);
        ec_read(EBR_OFF_TECHNOLOGY, 8'h78);
        @(negedge clock_i);
        upd_valid_i = 1'b1;
        upd_idx_i = 3'h3;
        upd_data_i = 16'hA5C3;
        @(negedge clock_i);
        upd_valid_i = 1'b0;
        ec_read(EBR_OFF_TECHNOLOGY, 8'hC3);
        ec_read(8'h07, 8'hA5);
        $display("test smbus and refresh finished");
        results();
    end
endmodule

//--- pkg/ebr_pkg.sv
// Constants and types for the host command port and battery information RAM
//
// Functional notes
// - Host talks only via command set ports
// - Read 0x80: command, address, data with OBF
// - Write 0x81: interrupt after each emptied byte
// - Burst disable 0x83: interrupt once buffer empty
// - SMBus codes 0x80/0xC0 reach battery RAM
// - Power unit word reads 0x0000 mWh
// - Battery words span two consecutive bytes
// - Battery words survive S4/S5 states
// - Host writes readable until controller refresh
package ebr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Host command bytes
    localparam logic [7:0] EBR_CMD_READ = 8'h80;
    localparam logic [7:0] EBR_CMD_WRITE = 8'h81;
    localparam logic [7:0] EBR_CMD_BURST_ON = 8'h82;
    localparam logic [7:0] EBR_CMD_BURST_OFF = 8'h83;
    localparam logic [7:0] EBR_CMD_QUERY = 8'h84;

    // Reply byte for burst enable; value is a plain default
    localparam logic [7:0] EBR_BURST_ACK = 8'h90;
    localparam logic [7:0] EBR_QUERY_NONE = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // SMBus command codes
    localparam logic [7:0] EBR_SMB_READ = 8'h80;
    localparam logic [7:0] EBR_SMB_WRITE = 8'hC0;

    ////////////////////////////////////////////////////////////////////////////
    // Status byte bit positions
    localparam int EBR_ST_OBF = 0;
    localparam int EBR_ST_IBF = 1;
    localparam int EBR_ST_CMD = 3;
    localparam int EBR_ST_BURST = 4;
    localparam int EBR_ST_SCI_EVT = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Battery RAM layout: eight words, low byte at the even address
    localparam int EBR_NUM_WORDS = 8;
    localparam int EBR_IDX_W = 3;
    localparam int EBR_BADDR_W = 4;
    localparam logic [7:0] EBR_RAM_BYTES = 8'h10;
    localparam logic [7:0] EBR_OFF_POWER_UNIT = 8'h00;
    localparam logic [7:0] EBR_OFF_DESIGN_CAP = 8'h02;
    localparam logic [7:0] EBR_OFF_LAST_FULL_CAP = 8'h04;
    localparam logic [7:0] EBR_OFF_TECHNOLOGY = 8'h06;
    localparam logic [7:0] EBR_OFF_DESIGN_VOLT = 8'h08;
    localparam logic [7:0] EBR_OFF_WARNING_CAP = 8'h0A;
    localparam logic [7:0] EBR_OFF_LOW_CAP = 8'h0C;
    localparam logic [7:0] EBR_OFF_CAP_STEP_ONE = 8'h0E;
    localparam logic [EBR_IDX_W-1:0] EBR_IDX_POWER_UNIT = 3'h0;
    localparam logic [15:0] EBR_WORD_RESET = 16'hFFFF;
    localparam logic [15:0] EBR_UNIT_MWH = 16'h0000;
    localparam logic [7:0] EBR_BYTE_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencer states
    typedef enum logic [1:0] {
        EBR_IDLE,
        EBR_RD_ADDR,
        EBR_WR_ADDR,
        EBR_WR_DATA
    } ebr_state_t;

endpackage

//--- verilog/ebr_bat_ram.sv
// Battery information RAM: eight 16-bit words with byte and word access
`timescale 1ns/1ps

module ebr_bat_ram (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic byte_we_i,
    input wire logic [ebr_pkg::EBR_BADDR_W-1:0] byte_addr_i,
    input wire logic [7:0] byte_data_i,
    input wire logic word_we_i,
    input wire logic [ebr_pkg::EBR_IDX_W-1:0] word_idx_i,
    input wire logic [15:0] word_data_i,
    input wire logic upd_we_i,
    input wire logic [ebr_pkg::EBR_IDX_W-1:0] upd_idx_i,
    input wire logic [15:0] upd_data_i,
    input wire logic [ebr_pkg::EBR_BADDR_W-1:0] rd_byte_addr_i,
    output logic [7:0] rd_byte_o,
    input wire logic [ebr_pkg::EBR_IDX_W-1:0] rd_word_idx_i,
    output logic [15:0] rd_word_o
);
    import ebr_pkg::*;

    typedef struct packed {
        logic [EBR_NUM_WORDS-1:0][15:0] words;
    } ebr_ram_st_t;

    ebr_ram_st_t st_reg;
    ebr_ram_st_t st_next;
    logic [15:0] byte_word;

    ////////////////////////////////////////////////////////////////////////////
    // Write ports; later assignments win, so a refresh overrides host data
    always_comb begin
        st_next = st_reg;
        if (byte_we_i) begin
            if (byte_addr_i[0]) begin
                st_next.words[byte_addr_i[EBR_BADDR_W-1:1]][15:8] = byte_data_i;
            end else begin
                st_next.words[byte_addr_i[EBR_BADDR_W-1:1]][7:0] = byte_data_i;
            end
        end
        if (word_we_i) begin
            st_next.words[word_idx_i] = word_data_i;
        end
        if (upd_we_i) begin
            st_next.words[upd_idx_i] = upd_data_i;
        end
    end

    // Only power-on reset loads 0xFFFF words; sleep states never reach this block
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= {EBR_NUM_WORDS{EBR_WORD_RESET}};
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reads; power unit is fixed at mWh whatever was written
    always_comb begin
        byte_word = st_reg.words[rd_byte_addr_i[EBR_BADDR_W-1:1]];
        if (rd_byte_addr_i[EBR_BADDR_W-1:1] == EBR_IDX_POWER_UNIT) begin
            byte_word = EBR_UNIT_MWH;
        end
        rd_byte_o = rd_byte_addr_i[0] ? byte_word[15:8] : byte_word[7:0];
        rd_word_o = (rd_word_idx_i == EBR_IDX_POWER_UNIT) ? EBR_UNIT_MWH : st_reg.words[rd_word_idx_i];
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    a_unit_fixed: assert property ((rd_word_idx_i == EBR_IDX_POWER_UNIT) |-> rd_word_o == EBR_UNIT_MWH)
        else $error("power unit word not fixed");
    a_refresh_wins: assert property ((upd_we_i && upd_idx_i != EBR_IDX_POWER_UNIT) |=>
        st_reg.words[$past(upd_idx_i)] == $past(upd_data_i))
        else $error("refresh did not land");
    a_byte_pair: assert property ((byte_we_i && byte_addr_i[0] && !word_we_i && !upd_we_i) |=>
        st_reg.words[$past(byte_addr_i[EBR_BADDR_W-1:1])][15:8] == $past(byte_data_i))
        else $error("odd byte not in high half");

endmodule

//--- verilog/ebr_host_cmd.sv
// Host command/data port interpreter with SMBus and refresh access to battery RAM
`timescale 1ns/1ps

module ebr_host_cmd (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic host_sel_cmd_i,
    input wire logic [7:0] host_wdata_i,
    output logic [7:0] host_rdata_o,
    output logic sci_o,
    input wire logic query_evt_i,
    input wire logic [7:0] query_code_i,
    input wire logic smb_valid_i,
    input wire logic [7:0] smb_cmd_i,
    input wire logic [ebr_pkg::EBR_IDX_W-1:0] smb_idx_i,
    input wire logic [15:0] smb_wdata_i,
    output logic [15:0] smb_rdata_o,
    output logic smb_done_o,
    output logic smb_err_o,
    input wire logic upd_valid_i,
    input wire logic [ebr_pkg::EBR_IDX_W-1:0] upd_idx_i,
    input wire logic [15:0] upd_data_i
);
    import ebr_pkg::*;

    typedef struct packed {
        logic [2:0] wr_sync;
        logic [2:0] rd_sync;
        logic wr_lvl;
        logic rd_lvl;
        ebr_state_t state;
        logic [7:0] in_buf;
        logic cmd_flag;
        logic ibf;
        logic obf;
        logic [7:0] out_buf;
        logic [7:0] addr;
        logic burst;
        logic sci_evt;
        logic [7:0] query_code;
        logic sci;
        logic [7:0] rdata;
        logic [15:0] smb_rdata;
        logic smb_done;
        logic smb_err;
    } ebr_host_st_t;

    localparam ebr_host_st_t ST_RESET = '{
        wr_sync: 3'h0, rd_sync: 3'h0, wr_lvl: 1'b0, rd_lvl: 1'b0, state: EBR_IDLE,
        in_buf: 8'h00, cmd_flag: 1'b0, ibf: 1'b0, obf: 1'b0, out_buf: 8'h00,
        addr: 8'h00, burst: 1'b0, sci_evt: 1'b0, query_code: EBR_QUERY_NONE, sci: 1'b0,
        rdata: 8'h00, smb_rdata: 16'h0000, smb_done: 1'b0, smb_err: 1'b0};

    ebr_host_st_t st_reg;
    ebr_host_st_t st_next;
    logic wr_ev;
    logic rd_ev;
    logic ram_byte_we;
    logic ram_word_we;
    logic addr_in_ram;
    logic [7:0] ram_rd_byte;
    logic [15:0] ram_rd_word;
    logic [7:0] status_byte;

    ebr_bat_ram ebr_bat_ram_i (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .byte_we_i(ram_byte_we),
        .byte_addr_i(st_reg.addr[EBR_BADDR_W-1:0]),
        .byte_data_i(st_reg.in_buf),
        .word_we_i(ram_word_we),
        .word_idx_i(smb_idx_i),
        .word_data_i(smb_wdata_i),
        .upd_we_i(upd_valid_i),
        .upd_idx_i(upd_idx_i),
        .upd_data_i(upd_data_i),
        .rd_byte_addr_i(st_reg.in_buf[EBR_BADDR_W-1:0]),
        .rd_byte_o(ram_rd_byte),
        .rd_word_idx_i(smb_idx_i),
        .rd_word_o(ram_rd_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Strobe filtering: a new high level counts once stages two and three agree
    always_comb begin
        wr_ev = (st_reg.wr_sync[1] == st_reg.wr_sync[2]) && st_reg.wr_sync[2] && !st_reg.wr_lvl;
        rd_ev = (st_reg.rd_sync[1] == st_reg.rd_sync[2]) && st_reg.rd_sync[2] && !st_reg.rd_lvl;
        status_byte = 8'h00;
        status_byte[EBR_ST_OBF] = st_reg.obf;
        status_byte[EBR_ST_IBF] = st_reg.ibf;
        status_byte[EBR_ST_CMD] = st_reg.cmd_flag;
        status_byte[EBR_ST_BURST] = st_reg.burst;
        status_byte[EBR_ST_SCI_EVT] = st_reg.sci_evt;
        addr_in_ram = st_reg.addr < EBR_RAM_BYTES;
        // Data byte of a write command lands now; out-of-range addresses drop it
        ram_byte_we = st_reg.ibf && !st_reg.cmd_flag && st_reg.state == EBR_WR_DATA && addr_in_ram;
        ram_word_we = smb_valid_i && smb_cmd_i == EBR_SMB_WRITE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencer
    always_comb begin
        st_next = st_reg;
        st_next.wr_sync = {st_reg.wr_sync[1:0], host_wr_i};
        st_next.rd_sync = {st_reg.rd_sync[1:0], host_rd_i};
        if (st_reg.wr_sync[1] == st_reg.wr_sync[2]) begin
            st_next.wr_lvl = st_reg.wr_sync[2];
        end
        if (st_reg.rd_sync[1] == st_reg.rd_sync[2]) begin
            st_next.rd_lvl = st_reg.rd_sync[2];
        end
        st_next.sci = 1'b0;
        st_next.smb_done = 1'b0;
        st_next.smb_err = 1'b0;

        // Host reading the data port empties the output buffer
        if (rd_ev && !host_sel_cmd_i) begin
            st_next.obf = 1'b0;
        end

        // One pending byte is worked off per cycle
        if (st_reg.ibf) begin
            st_next.ibf = 1'b0;
            if (st_reg.cmd_flag) begin
                // A command byte always restarts the sequence
                st_next.state = EBR_IDLE;
                if (st_reg.in_buf == EBR_CMD_READ) begin
                    st_next.state = EBR_RD_ADDR;
                    st_next.sci = 1'b1;
                end else if (st_reg.in_buf == EBR_CMD_WRITE) begin
                    st_next.state = EBR_WR_ADDR;
                    st_next.sci = 1'b1;
                end else if (st_reg.in_buf == EBR_CMD_BURST_ON) begin
                    st_next.burst = 1'b1;
                    st_next.out_buf = EBR_BURST_ACK;
                    st_next.obf = 1'b1;
                    st_next.sci = 1'b1;
                end else if (st_reg.in_buf == EBR_CMD_BURST_OFF) begin
                    st_next.burst = 1'b0;
                    st_next.sci = 1'b1;
                end else if (st_reg.in_buf == EBR_CMD_QUERY) begin
                    st_next.out_buf = st_reg.query_code;
                    st_next.obf = 1'b1;
                    st_next.sci = 1'b1;
                    st_next.sci_evt = 1'b0;
                    st_next.query_code = EBR_QUERY_NONE;
                end
            end else begin
                unique case (st_reg.state)
                    EBR_IDLE: begin
                        // Stray data byte outside a command: consumed, no reply
                        st_next.state = EBR_IDLE;
                    end
                    EBR_RD_ADDR: begin
                        // No interrupt for the address; the one with OBF serves
                        st_next.out_buf = (st_reg.in_buf < EBR_RAM_BYTES) ? ram_rd_byte : EBR_BYTE_ZERO;
                        st_next.obf = 1'b1;
                        st_next.sci = 1'b1;
                        st_next.state = EBR_IDLE;
                    end
                    EBR_WR_ADDR: begin
                        st_next.addr = st_reg.in_buf;
                        st_next.sci = 1'b1;
                        st_next.state = EBR_WR_DATA;
                    end
                    EBR_WR_DATA: begin
                        st_next.sci = 1'b1;
                        st_next.state = EBR_IDLE;
                    end
                endcase
            end
        end

        // New host byte; written after the consume so a fresh byte is never lost
        if (wr_ev) begin
            st_next.in_buf = host_wdata_i;
            st_next.cmd_flag = host_sel_cmd_i;
            st_next.ibf = 1'b1;
        end

        // Query event set wins over the clear by a query command
        if (query_evt_i) begin
            st_next.sci_evt = 1'b1;
            st_next.query_code = query_code_i;
            st_next.sci = 1'b1;
        end

        // SMBus word access, answered the following cycle
        if (smb_valid_i) begin
            if (smb_cmd_i == EBR_SMB_READ) begin
                st_next.smb_rdata = ram_rd_word;
                st_next.smb_done = 1'b1;
            end else if (smb_cmd_i == EBR_SMB_WRITE) begin
                st_next.smb_done = 1'b1;
            end else begin
                st_next.smb_err = 1'b1;
            end
        end

        st_next.rdata = host_sel_cmd_i ? status_byte : st_next.out_buf;
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign host_rdata_o = st_reg.rdata;
    assign sci_o = st_reg.sci;
    assign smb_rdata_o = st_reg.smb_rdata;
    assign smb_done_o = st_reg.smb_done;
    assign smb_err_o = st_reg.smb_err;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    sequence s_cmd_taken(logic [7:0] code);
        st_reg.ibf && st_reg.cmd_flag && st_reg.in_buf == code && !wr_ev;
    endsequence

    sequence s_data_taken(ebr_state_t s);
        st_reg.ibf && !st_reg.cmd_flag && st_reg.state == s && !wr_ev;
    endsequence

    a_read_cmd_irq: assert property (s_cmd_taken(EBR_CMD_READ) |=>
        sci_o && !st_reg.ibf && st_reg.state == EBR_RD_ADDR)
        else $error("read command not acknowledged");
    a_read_reply: assert property (s_data_taken(EBR_RD_ADDR) |=>
        st_reg.obf && sci_o && st_reg.state == EBR_IDLE)
        else $error("read data not returned with OBF");
    a_write_seq: assert property (s_cmd_taken(EBR_CMD_WRITE) |=>
        sci_o && st_reg.state == EBR_WR_ADDR ##0 (!st_reg.ibf)[*2])
        else $error("write command sequencing wrong");
    a_write_data: assert property (s_data_taken(EBR_WR_DATA) |-> ram_byte_we == addr_in_ram
        ##1 sci_o && st_reg.state == EBR_IDLE)
        else $error("write data byte not handled");
    a_burst_off: assert property (s_cmd_taken(EBR_CMD_BURST_OFF) |=>
        sci_o && !st_reg.burst && !st_reg.ibf)
        else $error("burst disable not handled");
    a_burst_ack: assert property (s_cmd_taken(EBR_CMD_BURST_ON) |=>
        st_reg.obf && st_reg.burst && st_reg.out_buf == EBR_BURST_ACK)
        else $error("burst acknowledge missing");
    a_obf_irq: assert property ($rose(st_reg.obf) |-> sci_o)
        else $error("OBF set without interrupt");
    a_smb_read: assert property ((smb_valid_i && smb_cmd_i == EBR_SMB_READ) |=>
        smb_done_o && smb_rdata_o == $past(ram_rd_word))
        else $error("SMBus read not answered");

endmodule
